// ==== rtl/pcg_top.sv ====
// Peripheral clock gating controller: gating registers for run, sleep and
// deep sleep per group, mode selection, gated unit clocks and bus faults.
// Assumes power mode inputs and unit access strobes come from logic on clock.
//
// Operation
// - Gate bit one passes unit clock
// - Gate bit zero stops unit clock
// - Access to gated unit gives bus fault
// - Gate bits reset to zero unless noted
// - Run, sleep, deep registers per group
// - Sleep registers apply only with auto gating
// - Deep group 0 resets with bit 6
// - Deep group 0 bit 3 gates watchdog
// - Group 0 bit 24 gates CAN unit
// - Run group 1 resets to zero
// - Run group 1 bit 18 gates timer 2
// - Run group 1 bit 17 gates timer 1
// - Run group 1 bit 16 gates timer 0
// - Run group 1 bit 4 gates sync serial
// - Run group 1 bit 0 gates async serial
// - Reserved bits are read-only
// - Extra register bits behave as reserved
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
module pcg_top
    import pcg_pkg::*;
#(
    parameter int UNITS = PCG_UNITS
) (
    input wire logic clock, // System clock, 100 MHz
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic [11:0] address, // Register byte address
    input wire logic [31:0] write_data, // Register write data
    input wire logic write_strobe, // One-cycle write request
    input wire logic read_strobe, // One-cycle read request
    output logic [31:0] read_data, // Read data, cycle after strobe
    input wire logic sleep_mode, // Core is in sleep
    input wire logic deep_sleep_mode, // Core is in deep sleep
    input wire logic [UNITS-1:0] unit_access, // Bus access aimed at a unit
    output logic [UNITS-1:0] unit_enable, // Effective clock enable per unit
    output logic [UNITS-1:0] unit_bus_fault, // Fault pulse per unit
    output logic [UNITS-1:0] unit_clock // Gated clock per unit
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic [31:0] run_gate_group0;
    logic [31:0] sleep_gate_group0;
    logic [31:0] deep_sleep_gate_group0;
    logic [31:0] run_gate_group1;
    logic [31:0] sleep_gate_group1;
    logic [31:0] deep_sleep_gate_group1;
    logic [31:0] run_clock_config_reg;
    logic [31:0] next_run_gate_group0;
    logic [31:0] next_sleep_gate_group0;
    logic [31:0] next_deep_sleep_gate_group0;
    logic [31:0] next_run_gate_group1;
    logic [31:0] next_sleep_gate_group1;
    logic [31:0] next_deep_sleep_gate_group1;
    logic [31:0] next_run_clock_config_reg;
    logic [31:0] g0_write_value;
    logic [31:0] g1_write_value;
    logic [31:0] cfg_write_value;

    // Only enable fields take write data; reserved bits keep fixed values
    always_comb begin
        g0_write_value = (write_data & PCG_G0_WR_MASK) | PCG_G0_FIXED;
        g1_write_value = (write_data & PCG_G1_WR_MASK) | PCG_G1_FIXED;
        cfg_write_value = write_data & PCG_CFG_WR_MASK;
        next_run_gate_group0 = run_gate_group0;
        next_sleep_gate_group0 = sleep_gate_group0;
        next_deep_sleep_gate_group0 = deep_sleep_gate_group0;
        next_run_gate_group1 = run_gate_group1;
        next_sleep_gate_group1 = sleep_gate_group1;
        next_deep_sleep_gate_group1 = deep_sleep_gate_group1;
        next_run_clock_config_reg = run_clock_config_reg;
        if (write_strobe) begin
            case (address)
                PCG_OFS_RUN_G0: begin
                    next_run_gate_group0 = g0_write_value;
                end
                PCG_OFS_SLEEP_G0: begin
                    next_sleep_gate_group0 = g0_write_value;
                end
                PCG_OFS_DEEP_G0: begin
                    next_deep_sleep_gate_group0 = g0_write_value;
                end
                PCG_OFS_RUN_G1: begin
                    next_run_gate_group1 = g1_write_value;
                end
                PCG_OFS_SLEEP_G1: begin
                    next_sleep_gate_group1 = g1_write_value;
                end
                PCG_OFS_DEEP_G1: begin
                    next_deep_sleep_gate_group1 = g1_write_value;
                end
                PCG_OFS_CLK_CFG: begin
                    next_run_clock_config_reg = cfg_write_value;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            run_gate_group0 <= PCG_G0_RESET;
            sleep_gate_group0 <= PCG_G0_RESET;
            deep_sleep_gate_group0 <= PCG_G0_RESET;
            run_gate_group1 <= PCG_G1_RESET;
            sleep_gate_group1 <= PCG_G1_RESET;
            deep_sleep_gate_group1 <= PCG_G1_RESET;
            run_clock_config_reg <= PCG_CFG_RESET;
        end else begin
            run_gate_group0 <= next_run_gate_group0;
            sleep_gate_group0 <= next_sleep_gate_group0;
            deep_sleep_gate_group0 <= next_deep_sleep_gate_group0;
            run_gate_group1 <= next_run_gate_group1;
            sleep_gate_group1 <= next_sleep_gate_group1;
            deep_sleep_gate_group1 <= next_deep_sleep_gate_group1;
            run_clock_config_reg <= next_run_clock_config_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power mode tracking

    pcg_mode_t mode;
    pcg_mode_t next_mode;

    // Deep sleep takes precedence when both mode inputs are high
    always_comb begin
        next_mode = PCG_MODE_RUN;
        if (deep_sleep_mode) begin
            next_mode = PCG_MODE_DEEP;
        end else if (sleep_mode) begin
            next_mode = PCG_MODE_SLEEP;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode <= PCG_MODE_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective enables

    logic auto_gating_select;
    logic [31:0] active_group0;
    logic [31:0] active_group1;
    logic [UNITS-1:0] next_unit_enable;

    assign auto_gating_select = run_clock_config_reg[PCG_CFG_AUTO_GATE_BIT];

    always_comb begin
        active_group0 = run_gate_group0;
        active_group1 = run_gate_group1;
        case (mode)
            PCG_MODE_RUN: begin
            end
            PCG_MODE_SLEEP: begin
                if (auto_gating_select) begin
                    active_group0 = sleep_gate_group0;
                    active_group1 = sleep_gate_group1;
                end
            end
            PCG_MODE_DEEP: begin
                if (auto_gating_select) begin
                    active_group0 = deep_sleep_gate_group0;
                    active_group1 = deep_sleep_gate_group1;
                end
            end
            default: begin
            end
        endcase
        next_unit_enable = '0;
        next_unit_enable[PCG_U_ASYNC_SERIAL0_CLOCK_GATE] = active_group1[PCG_G1_ASYNC_SERIAL0_CLOCK_GATE_BIT];
        next_unit_enable[PCG_U_SYNC_SERIAL0_CLOCK_GATE] = active_group1[PCG_G1_SYNC_SERIAL0_CLOCK_GATE_BIT];
        next_unit_enable[PCG_U_GP_COUNTER0_CLOCK_GATE] = active_group1[PCG_G1_GP_COUNTER0_CLOCK_GATE_BIT];
        next_unit_enable[PCG_U_GP_COUNTER1_CLOCK_GATE] = active_group1[PCG_G1_GP_COUNTER1_CLOCK_GATE_BIT];
        next_unit_enable[PCG_U_GP_COUNTER2_CLOCK_GATE] = active_group1[PCG_G1_GP_COUNTER2_CLOCK_GATE_BIT];
        next_unit_enable[PCG_U_WDT] = active_group0[PCG_G0_WDT_BIT];
        next_unit_enable[PCG_U_CONTROLLER_AREA0_CLOCK_GATE] = active_group0[PCG_G0_CONTROLLER_AREA0_CLOCK_GATE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus fault on access to an unclocked unit

    logic [UNITS-1:0] next_unit_bus_fault;

    always_comb begin
        next_unit_bus_fault = unit_access & ~unit_enable;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            unit_enable <= '0;
            unit_bus_fault <= '0;
        end else begin
            unit_enable <= next_unit_enable;
            unit_bus_fault <= next_unit_bus_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gated unit clocks

    for (genvar u = 0; u < UNITS; u++) begin : g_gate
        pcg_clock_gate u_gate (
            .clock(clock),
            .enable(unit_enable[u]),
            .gated_clock(unit_clock[u])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [31:0] status_word;
    logic [31:0] next_read_data;

    always_comb begin
        status_word = '0;
        status_word[PCG_ST_ENABLE_LSB +: UNITS] = unit_enable;
        status_word[PCG_ST_MODE_LSB +: 3] = mode;
        next_read_data = '0;
        if (read_strobe) begin
            case (address)
                PCG_OFS_RUN_G0: begin
                    next_read_data = run_gate_group0;
                end
                PCG_OFS_SLEEP_G0: begin
                    next_read_data = sleep_gate_group0;
                end
                PCG_OFS_DEEP_G0: begin
                    next_read_data = deep_sleep_gate_group0;
                end
                PCG_OFS_RUN_G1: begin
                    next_read_data = run_gate_group1;
                end
                PCG_OFS_SLEEP_G1: begin
                    next_read_data = sleep_gate_group1;
                end
                PCG_OFS_DEEP_G1: begin
                    next_read_data = deep_sleep_gate_group1;
                end
                PCG_OFS_CLK_CFG: begin
                    next_read_data = run_clock_config_reg;
                end
                PCG_OFS_STATUS: begin
                    next_read_data = status_word;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= '0;
        end else begin
            read_data <= next_read_data;
        end
    end

endmodule

// ==== rtl/pcg_pkg.sv ====
// Package for the peripheral clock gating block: offsets, field layout,
// reset values, unit indices and power mode codes.
// Assumes a 12-bit byte address on the register port and 32-bit data.
package pcg_pkg;

    localparam int PCG_ADDR_W = 12;
    localparam int PCG_DATA_W = 32;
    localparam int PCG_UNITS = 7;

    // Register byte offsets
    localparam logic [11:0] PCG_OFS_RUN_G0 = 12'h100;
    localparam logic [11:0] PCG_OFS_RUN_G1 = 12'h104;
    localparam logic [11:0] PCG_OFS_SLEEP_G0 = 12'h110;
    localparam logic [11:0] PCG_OFS_SLEEP_G1 = 12'h114;
    localparam logic [11:0] PCG_OFS_DEEP_G0 = 12'h120;
    localparam logic [11:0] PCG_OFS_DEEP_G1 = 12'h124;
    localparam logic [11:0] PCG_OFS_CLK_CFG = 12'h1f0;
    localparam logic [11:0] PCG_OFS_STATUS = 12'h1f4;

    // Group 0 field positions
    localparam int PCG_G0_CONTROLLER_AREA0_CLOCK_GATE_BIT = 24;
    localparam int PCG_G0_WDT_BIT = 3;
    localparam int PCG_G0_FIXED_ONE_BIT = 6;

    // Group 1 field positions
    localparam int PCG_G1_GP_COUNTER2_CLOCK_GATE_BIT = 18;
    localparam int PCG_G1_GP_COUNTER1_CLOCK_GATE_BIT = 17;
    localparam int PCG_G1_GP_COUNTER0_CLOCK_GATE_BIT = 16;
    localparam int PCG_G1_SYNC_SERIAL0_CLOCK_GATE_BIT = 4;
    localparam int PCG_G1_ASYNC_SERIAL0_CLOCK_GATE_BIT = 0;

    // Configuration register field
    localparam int PCG_CFG_AUTO_GATE_BIT = 0;

    // Status register fields
    localparam int PCG_ST_ENABLE_LSB = 0;
    localparam int PCG_ST_MODE_LSB = 8;

    // Writable masks and fixed read-one bits
    localparam logic [31:0] PCG_G0_WR_MASK = 32'h01000008;
    localparam logic [31:0] PCG_G1_WR_MASK = 32'h00070011;
    localparam logic [31:0] PCG_CFG_WR_MASK = 32'h00000001;
    localparam logic [31:0] PCG_G0_FIXED = 32'h00000040;
    localparam logic [31:0] PCG_G1_FIXED = 32'h00000000;

    // Reset values
    localparam logic [31:0] PCG_G0_RESET = 32'h00000040;
    localparam logic [31:0] PCG_G1_RESET = 32'h00000000;
    localparam logic [31:0] PCG_CFG_RESET = 32'h00000000;

    // Unit indices on the gated clock and fault vectors
    localparam int PCG_U_ASYNC_SERIAL0_CLOCK_GATE = 0;
    localparam int PCG_U_SYNC_SERIAL0_CLOCK_GATE = 1;
    localparam int PCG_U_GP_COUNTER0_CLOCK_GATE = 2;
    localparam int PCG_U_GP_COUNTER1_CLOCK_GATE = 3;
    localparam int PCG_U_GP_COUNTER2_CLOCK_GATE = 4;
    localparam int PCG_U_WDT = 5;
    localparam int PCG_U_CONTROLLER_AREA0_CLOCK_GATE = 6;

    typedef enum logic [2:0] {
        PCG_MODE_RUN = 3'b001,
        PCG_MODE_SLEEP = 3'b010,
        PCG_MODE_DEEP = 3'b100
    } pcg_mode_t;

endpackage

// ==== rtl/pcg_clock_gate.sv ====
// Glitch-free clock gate cell for one unit.
// Assumes enable is synchronous to clock; the latch is open while clock is low.
`timescale 1ns/100ps
module pcg_clock_gate (
    input wire logic clock, // Source clock
    input wire logic enable, // Pass the clock while high
    output logic gated_clock // Gated unit clock
);

    logic enable_latched;

    // The latched enable only changes while clock is low, so no pulse is cut short
    always_latch begin
        if (!clock) begin
            enable_latched <= enable;
        end
    end

    assign gated_clock = clock & enable_latched;

endmodule

// ==== verif/pcg_asserts.sv ====
// Checker for the peripheral clock gating block, bound into pcg_top.
// Sees only the top ports; tracks the config and two gate bits itself.
`timescale 1ns/100ps
module pcg_asserts
    import pcg_pkg::*;
#(
    parameter int UNITS = PCG_UNITS
) (
    input wire logic clock, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [11:0] address, // Register byte address
    input wire logic [31:0] write_data, // Write data
    input wire logic write_strobe, // Write request
    input wire logic read_strobe, // Read request
    input wire logic [31:0] read_data, // Read data
    input wire logic sleep_mode, // Sleep level
    input wire logic deep_sleep_mode, // Deep sleep level
    input wire logic [UNITS-1:0] unit_access, // Unit access pulses
    input wire logic [UNITS-1:0] unit_enable, // Unit enables
    input wire logic [UNITS-1:0] unit_bus_fault, // Fault pulses
    input wire logic [UNITS-1:0] unit_clock // Gated clocks
);
    logic auto_q, wdt_q, can_q, next_auto_q, next_wdt_q, next_can_q;

    always_comb begin
        next_auto_q = auto_q;
        next_wdt_q = wdt_q;
        next_can_q = can_q;
        if (write_strobe && address == PCG_OFS_CLK_CFG) next_auto_q = write_data[0];
        if (write_strobe && address == PCG_OFS_DEEP_G0) next_wdt_q = write_data[3];
        if (write_strobe && address == PCG_OFS_SLEEP_G0) next_can_q = write_data[24];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            auto_q <= 1'b0;
            wdt_q <= 1'b0;
            can_q <= 1'b0;
        end else begin
            auto_q <= next_auto_q;
            wdt_q <= next_wdt_q;
            can_q <= next_can_q;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    gated_fault_a: assert property ((unit_access & ~unit_enable) != '0 |=>
        (unit_bus_fault & $past(unit_access) & ~$past(unit_enable)) != '0) else $error("no fault");
    clean_fault_a: assert property (1'b1 |=>
        (unit_bus_fault & ~($past(unit_access) & ~$past(unit_enable))) == '0) else $error("bad fault");
    g1_readback_a: assert property (write_strobe && address == PCG_OFS_RUN_G1 ##1
        read_strobe && address == PCG_OFS_RUN_G1 |=>
        read_data == ($past(write_data, 2) & PCG_G1_WR_MASK)) else $error("g1 readback");
    g0_readback_a: assert property (write_strobe && address == PCG_OFS_DEEP_G0 ##1
        read_strobe && address == PCG_OFS_DEEP_G0 |=>
        read_data == (($past(write_data, 2) & PCG_G0_WR_MASK) | 32'h00000040))
        else $error("g0 readback");
    run_enable_a: assert property (write_strobe && address == PCG_OFS_RUN_G1 && !auto_q
        ##1 !(write_strobe && address == PCG_OFS_RUN_G1) |=>
        unit_enable[PCG_U_ASYNC_SERIAL0_CLOCK_GATE] == $past(write_data[0], 2)) else $error("run enable");
    deep_wdt_a: assert property ((auto_q && deep_sleep_mode && !write_strobe)[*3] |->
        unit_enable[PCG_U_WDT] == wdt_q) else $error("deep wdt enable");
    sleep_can_a: assert property ((auto_q && sleep_mode && !deep_sleep_mode && !write_strobe)[*3]
        |-> unit_enable[PCG_U_CONTROLLER_AREA0_CLOCK_GATE] == can_q) else $error("sleep can enable");
    clock_follow_a: assert property (@(negedge clock) disable iff (!reset_n)
        $stable(unit_enable)[*2] |-> unit_clock == unit_enable) else $error("gated clock");
endmodule

bind pcg_top pcg_asserts #(.UNITS(UNITS)) u_asserts (.clock(clock), .reset_n(reset_n),
    .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .sleep_mode(sleep_mode),
    .deep_sleep_mode(deep_sleep_mode), .unit_access(unit_access),
    .unit_enable(unit_enable), .unit_bus_fault(unit_bus_fault), .unit_clock(unit_clock));

// ==== verif/peripheral_clock_gating_test.sv ====
// Self-checking bench for pcg_top with a register and enable model.
// Assumes the checker file is compiled alongside.
`timescale 1ns/100ps
module peripheral_clock_gating_test
    import pcg_pkg::*;
;
    logic clock = 1'b0, reset_n = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0;
    logic sleep_mode = 1'b0, deep_sleep_mode = 1'b0;
    logic [11:0] address = '0;
    logic [31:0] write_data = '0, read_data;
    logic [6:0] unit_access = '0, unit_enable, unit_bus_fault, unit_clock, v;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    logic [11:0] ofs [7] = '{PCG_OFS_RUN_G0, PCG_OFS_RUN_G1, PCG_OFS_SLEEP_G0,
        PCG_OFS_SLEEP_G1, PCG_OFS_DEEP_G0, PCG_OFS_DEEP_G1, PCG_OFS_CLK_CFG};
    logic [31:0] wm [7] = '{PCG_G0_WR_MASK, PCG_G1_WR_MASK, PCG_G0_WR_MASK, PCG_G1_WR_MASK,
        PCG_G0_WR_MASK, PCG_G1_WR_MASK, PCG_CFG_WR_MASK};
    logic [31:0] fx [7] = '{32'h40, 32'h0, 32'h40, 32'h0, 32'h40, 32'h0, 32'h0};
    logic [31:0] m [7];

    pcg_top u_dut (.clock(clock), .reset_n(reset_n), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
        .unit_access(unit_access), .unit_enable(unit_enable),
        .unit_bus_fault(unit_bus_fault), .unit_clock(unit_clock));

    initial begin
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", n, e, g);
            mismatches++;
        end
    endtask

    // Enables as the rules derive them from mode, auto gating and registers
    function automatic logic [6:0] exp_en();
        logic [31:0] g0, g1;
        g0 = m[0];
        g1 = m[1];
        if (m[6][0] && deep_sleep_mode) begin
            g0 = m[4];
            g1 = m[5];
        end else if (m[6][0] && sleep_mode) begin
            g0 = m[2];
            g1 = m[3];
        end
        return {g0[24], g0[3], g1[18], g1[17], g1[16], g1[4], g1[0]};
    endfunction

    task automatic wr(input int i, input logic [31:0] d);
        @(posedge clock);
        address <= ofs[i];
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        m[i] = (d & wm[i]) | fx[i];
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 check("read_data", e, read_data);
    endtask

    // Write then read back in the very next cycle
    task automatic wrrd(input int i, input logic [31:0] d);
        wr(i, d);
        address <= ofs[i];
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 check("readback", m[i], read_data);
    endtask

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        m = '{32'h40, 32'h0, 32'h40, 32'h0, 32'h40, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) rd(ofs[i], m[i]);
        check("unit_enable", 32'h0, 32'(unit_enable));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(16));
        do_reset();
        for (int i = 0; i < 7; i++) begin
            wrrd(i, 32'hffffffff);
            wrrd(i, 32'h0);
            wrrd(i, $urandom);
        end
        rd(12'h108, 32'h0);
        for (int a = 0; a < 2; a++) begin
            for (int md = 0; md < 3; md++) begin
                for (int i = 0; i < 6; i++) wr(i, $urandom);
                wr(6, 32'(a));
                sleep_mode <= md > 0;
                deep_sleep_mode <= md == 2;
                repeat (3) @(posedge clock);
                #1 check("unit_enable", 32'(exp_en()), 32'(unit_enable));
                rd(PCG_OFS_STATUS, {21'h0, 3'(1 << md), 1'b0, exp_en()});
                @(posedge clock);
                #1 check("read_data idle", 32'h0, read_data);
                repeat (4) begin
                    v = 7'($urandom);
                    @(posedge clock);
                    unit_access <= v;
                    @(posedge clock);
                    unit_access <= '0;
                    #1 check("unit_bus_fault", 32'(v & ~exp_en()), 32'(unit_bus_fault));
                end
                @(posedge clock);
                #2 check("unit_clock", 32'(exp_en()), 32'(unit_clock));
                #5 check("unit_clock low", 32'h0, 32'(unit_clock));
            end
        end
        @(posedge clock);
        sleep_mode <= 1'b0;
        deep_sleep_mode <= 1'b0;
        do_reset();
        end_of_test();
    end
endmodule
